// File: rtl/pkt_handler_cfg.sv
// Packet handler configuration registers and frame acceptance control.
// Assumes a byte-stream receiver, a FIFO with byte count outside.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "pkt_handler_params.svh"
module pkt_handler_cfg (
    // Clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     rstn_in,
    // Register port
    input  wire logic [7:0]               reg_addr_in,
    input  wire pkt_handler_pkg::reg_byte_t reg_wdata_in,
    input  wire logic                     reg_wr_in,
    input  wire logic                     reg_rd_in,
    output pkt_handler_pkg::reg_byte_t    reg_rdata_out,
    // Receive byte stream
    input  wire logic                     rx_sync_in,
    input  wire logic                     rx_byte_valid_in,
    input  wire logic [7:0]               rx_byte_in,
    input  wire logic                     rx_crc_done_in,
    input  wire logic                     rx_crc_ok_in,
    // FIFO status
    input  wire logic [6:0]               queue_count_in,
    // Modem controls
    output logic                          frame_length_kind_out,
    output pkt_handler_pkg::line_coding_t line_balance_coding_out,
    output logic                          check_enable_out,
    output logic                          check_scramble_variant_out,
    output logic                          processing_style_out,
    output logic                          legacy_home_compat_out,
    output logic                          beacon_active_out,
    output pkt_handler_pkg::body_len_t    body_len_out,
    output logic                          tx_len_from_reg_out,
    output logic                          tx_start_out,
    // Receive results
    output logic                          rx_store_out,
    output logic [7:0]                    rx_store_byte_out,
    output logic                          fifo_flush_out,
    output logic                          rx_restart_out,
    output logic                          body_ready_flag_out,
    output logic                          queue_level_flag_out,
    output logic                          queue_empty_flag_out,
    output logic                          irq_out
);
    import pkt_handler_pkg::*;

    // ==========================================================
    // Configuration registers
    reg_byte_t cfg_pri_r;
    reg_byte_t cfg_sec_r;
    reg_byte_t len_lo_r;
    reg_byte_t station_r;
    reg_byte_t bcast_r;
    reg_byte_t thresh_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_en_r;
    logic [3:0] irq_evt;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = reg_wr_in && (a == o);
    endfunction

    // Reserved codes are stored as written; hardware treats them as off
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            cfg_pri_r <= `RST_PKT_CFG_PRI;
            cfg_sec_r <= `RST_PKT_CFG_SEC;
            len_lo_r  <= `RST_PAYLOAD_LEN_LO;
            station_r <= `RST_STATION_ADDR;
            bcast_r   <= `RST_BCAST_ADDR;
            thresh_r  <= `RST_FIFO_THRESH;
        end else begin
            if (hit(reg_addr_in, `OFS_PKT_CFG_PRI)) begin
                cfg_pri_r <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `OFS_PKT_CFG_SEC)) begin
                cfg_sec_r <= {1'b0, reg_wdata_in[6:0]};
            end
            if (hit(reg_addr_in, `OFS_PAYLOAD_LEN_LO)) begin
                len_lo_r <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `OFS_STATION_ADDR)) begin
                station_r <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `OFS_BCAST_ADDR)) begin
                bcast_r <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `OFS_FIFO_THRESH)) begin
                thresh_r <= {reg_wdata_in[7], 1'b0, reg_wdata_in[5:0]};
            end
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `OFS_PKT_CFG_PRI:    reg_rdata_out <= cfg_pri_r;
                `OFS_PKT_CFG_SEC:    reg_rdata_out <= cfg_sec_r;
                `OFS_PAYLOAD_LEN_LO: reg_rdata_out <= len_lo_r;
                `OFS_STATION_ADDR:   reg_rdata_out <= station_r;
                `OFS_BCAST_ADDR:     reg_rdata_out <= bcast_r;
                `OFS_FIFO_THRESH:    reg_rdata_out <= thresh_r;
                `OFS_IRQ_STATUS:     reg_rdata_out <= {4'h0, irq_stat_r};
                `OFS_IRQ_ENABLE:     reg_rdata_out <= {4'h0, irq_en_r};
                `OFS_QUEUE_COUNT:    reg_rdata_out <= {1'b0, queue_count_in};
                default:             reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ==========================================================
    // Decoded controls
    line_coding_t coding;
    addr_filter_t filt;
    body_len_t    body_len;
    logic         level_hit;
    logic         start_cond;

    always_comb begin
        coding   = line_coding_t'(cfg_pri_r[6:5]);
        filt     = addr_filter_t'(cfg_pri_r[2:1]);
        body_len = {cfg_sec_r[2:0], len_lo_r};
        // Count >= mark + 1, same as count > mark
        level_hit = {1'b0, queue_count_in} >
                    {2'b00, thresh_r[5:0]};
        if (thresh_r[`BIT_SEND_TRIG]) begin
            start_cond = (queue_count_in != 7'h00);
        end else begin
            start_cond = level_hit;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            frame_length_kind_out      <= 1'b1;
            line_balance_coding_out    <= CODE_NONE;
            check_enable_out           <= 1'b1;
            check_scramble_variant_out <= 1'b0;
            processing_style_out       <= 1'b1;
            legacy_home_compat_out     <= 1'b0;
            beacon_active_out          <= 1'b0;
            body_len_out               <= 11'h000;
            tx_len_from_reg_out        <= 1'b0;
            tx_start_out               <= 1'b0;
            queue_level_flag_out       <= 1'b0;
            queue_empty_flag_out       <= 1'b1;
        end else begin
            frame_length_kind_out <= cfg_pri_r[`BIT_FRAME_KIND];
            // Reserved coding falls back to none, never a guess
            line_balance_coding_out <= (coding == CODE_RESERVED) ?
                                       CODE_NONE : coding;
            check_enable_out <= cfg_pri_r[`BIT_CHECK_EN];
            check_scramble_variant_out <=
                cfg_pri_r[`BIT_SCRAMBLE_VAR];
            processing_style_out <= cfg_sec_r[`BIT_PROC_STYLE];
            legacy_home_compat_out <= cfg_sec_r[`BIT_LEGACY_HOME];
            beacon_active_out <= cfg_sec_r[`BIT_BEACON] &&
                                 !cfg_pri_r[`BIT_FRAME_KIND];
            body_len_out <= body_len;
            tx_len_from_reg_out <= !cfg_pri_r[`BIT_FRAME_KIND];
            tx_start_out <= start_cond;
            queue_level_flag_out <= level_hit;
            queue_empty_flag_out <= (queue_count_in == 7'h00);
        end
    end

    // ==========================================================
    // Receive acceptance
    rx_state_t  rx_state_r;
    body_len_t  rx_cnt_r;
    logic       addr_ok;
    logic       len_over;

    always_comb begin
        case (filt)
            FILT_OWN:       addr_ok = (rx_byte_in == station_r);
            FILT_OWN_BCAST: addr_ok = (rx_byte_in == station_r) ||
                                      (rx_byte_in == bcast_r);
            default:        addr_ok = 1'b1;
        endcase
        // Variable frames beyond the maximum are dropped
        len_over = cfg_pri_r[`BIT_FRAME_KIND] &&
                   (rx_cnt_r >= body_len);
    end

    logic bad_check;
    logic good_check;
    assign bad_check  = rx_crc_done_in && cfg_pri_r[`BIT_CHECK_EN] &&
                        !rx_crc_ok_in;
    assign good_check = rx_crc_done_in &&
                        (rx_crc_ok_in || !cfg_pri_r[`BIT_CHECK_EN]);

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r   <= 11'h000;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    rx_cnt_r <= 11'h000;
                    if (rx_sync_in) begin
                        rx_state_r <= (filt == FILT_NONE ||
                                       filt == FILT_RESERVED) ?
                                      RX_BODY : RX_ADDR;
                    end
                end
                RX_ADDR: begin
                    if (rx_byte_valid_in) begin
                        rx_state_r <= addr_ok ? RX_BODY : RX_DROP;
                        rx_cnt_r   <= 11'h001;
                    end
                end
                RX_BODY: begin
                    if (rx_byte_valid_in) begin
                        rx_cnt_r <= rx_cnt_r + 11'h001;
                        if (len_over) begin
                            rx_state_r <= RX_DROP;
                        end
                    end
                    if (rx_crc_done_in) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                RX_DROP: rx_state_r <= RX_IDLE;
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Stream outputs and frame-end actions
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            rx_store_out        <= 1'b0;
            rx_store_byte_out   <= 8'h00;
            fifo_flush_out      <= 1'b0;
            rx_restart_out      <= 1'b0;
            body_ready_flag_out <= 1'b0;
        end else begin
            rx_store_out <= rx_byte_valid_in && !len_over &&
                ((rx_state_r == RX_BODY) ||
                 (rx_state_r == RX_ADDR && addr_ok));
            rx_store_byte_out <= rx_byte_in;
            // Keep-buffer set: bad frame still handed up, not flushed
            fifo_flush_out <= (rx_state_r == RX_DROP) ||
                (bad_check && !cfg_pri_r[`BIT_KEEP_BUF]);
            rx_restart_out <= (rx_state_r == RX_DROP) ||
                (bad_check && !cfg_pri_r[`BIT_KEEP_BUF]);
            body_ready_flag_out <= (rx_state_r == RX_BODY) &&
                (good_check ||
                 (bad_check && cfg_pri_r[`BIT_KEEP_BUF]));
        end
    end

    // ==========================================================
    // Interrupts; a new event beats a clear in the same cycle
    always_comb begin
        irq_evt = 4'h0;
        irq_evt[`IRQ_BODY_READY] = (rx_state_r == RX_BODY) &&
            (good_check || (bad_check && cfg_pri_r[`BIT_KEEP_BUF]));
        irq_evt[`IRQ_LEVEL]      = level_hit && !queue_level_flag_out;
        irq_evt[`IRQ_BAD_CHECK]  = bad_check;
        irq_evt[`IRQ_ADDR_DROP]  = (rx_state_r == RX_DROP);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            irq_stat_r <= 4'h0;
            irq_en_r   <= 4'h0;
            irq_out    <= 1'b0;
        end else begin
            if (hit(reg_addr_in, `OFS_IRQ_ENABLE)) begin
                irq_en_r <= reg_wdata_in[3:0];
            end
            if (hit(reg_addr_in, `OFS_IRQ_CLEAR)) begin
                irq_stat_r <= (irq_stat_r & ~reg_wdata_in[3:0]) | irq_evt;
            end else begin
                irq_stat_r <= irq_stat_r | irq_evt;
            end
            irq_out <= |(irq_stat_r & irq_en_r);
        end
    end
endmodule

// File: rtl/pkt_handler_params.svh
// Register map, field positions, reset values of the packet handler.
// Assumes inclusion by the design module only.
`ifndef PKT_HANDLER_PARAMS_SVH
`define PKT_HANDLER_PARAMS_SVH
`define OFS_PKT_CFG_PRI      8'h30
`define OFS_PKT_CFG_SEC      8'h31
`define OFS_PAYLOAD_LEN_LO   8'h32
`define OFS_STATION_ADDR     8'h33
`define OFS_BCAST_ADDR       8'h34
`define OFS_FIFO_THRESH      8'h35
`define OFS_IRQ_STATUS       8'h38
`define OFS_IRQ_ENABLE       8'h39
`define OFS_IRQ_CLEAR        8'h3A
`define OFS_QUEUE_COUNT      8'h3B
`define RST_PKT_CFG_PRI      8'h90
`define RST_PKT_CFG_SEC      8'h40
`define RST_PAYLOAD_LEN_LO   8'h40
`define RST_STATION_ADDR     8'h00
`define RST_BCAST_ADDR       8'h00
`define RST_FIFO_THRESH      8'h8F
`define BIT_FRAME_KIND       7
`define BIT_CHECK_EN         4
`define BIT_KEEP_BUF         3
`define BIT_SCRAMBLE_VAR     0
`define BIT_PROC_STYLE       6
`define BIT_LEGACY_HOME      5
`define BIT_BEACON           3
`define BIT_SEND_TRIG        7
`define IRQ_BODY_READY       0
`define IRQ_LEVEL            1
`define IRQ_BAD_CHECK        2
`define IRQ_ADDR_DROP        3
`endif

// File: rtl/pkt_handler_pkg.sv
// Types shared by the packet handler configuration block.
// Does not include the params header or use its macros.
package pkt_handler_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [10:0] body_len_t;
    typedef enum logic [1:0] {
        CODE_NONE       = 2'h0,
        CODE_MANCHESTER = 2'h1,
        CODE_WHITENING  = 2'h2,
        CODE_RESERVED   = 2'h3
    } line_coding_t;
    typedef enum logic [1:0] {
        FILT_NONE      = 2'h0,
        FILT_OWN       = 2'h1,
        FILT_OWN_BCAST = 2'h2,
        FILT_RESERVED  = 2'h3
    } addr_filter_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_ADDR = 2'h1,
        RX_BODY = 2'h3,
        RX_DROP = 2'h2
    } rx_state_t;
endpackage

// File: tb/pkt_handler_cfg_bench.sv
// Bench for the packet handler configuration block.
// Drives registers, queue count and, through the model, the stream.
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module pkt_handler_cfg_bench;
    import pkt_handler_pkg::*;
    logic sys_clk_in, rstn_in, reg_wr_in, reg_rd_in, rx_sync, rx_vld;
    logic crc_done, crc_ok, frame_length_kind_out, check_enable_out;
    logic check_scramble_variant_out, processing_style_out, irq_out;
    logic legacy_home_compat_out, beacon_active_out, tx_len_from_reg_out;
    logic tx_start_out, rx_store_out, fifo_flush_out, rx_restart_out;
    logic body_ready_flag_out, queue_level_flag_out, queue_empty_flag_out;
    logic [7:0] reg_addr_in, rx_byte, rx_store_byte_out;
    logic [6:0] queue_count_in;
    reg_byte_t reg_wdata_in, reg_rdata_out;
    line_coding_t line_balance_coding_out;
    body_len_t body_len_out;
    int errors = 0;
    int check_count = 0;
    pkt_handler_cfg u_pkt_handler_cfg (
        .sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .rx_sync_in(rx_sync),
        .rx_byte_valid_in(rx_vld), .rx_byte_in(rx_byte),
        .rx_crc_done_in(crc_done), .rx_crc_ok_in(crc_ok), .queue_count_in,
        .frame_length_kind_out, .line_balance_coding_out, .check_enable_out,
        .check_scramble_variant_out, .processing_style_out,
        .legacy_home_compat_out, .beacon_active_out, .body_len_out,
        .tx_len_from_reg_out, .tx_start_out, .rx_store_out,
        .rx_store_byte_out, .fifo_flush_out, .rx_restart_out,
        .body_ready_flag_out, .queue_level_flag_out, .queue_empty_flag_out,
        .irq_out);
    rx_stream_model u_src (
        .sys_clk_in, .rx_sync_out(rx_sync), .rx_byte_valid_out(rx_vld),
        .rx_byte_out(rx_byte), .rx_crc_done_out(crc_done),
        .rx_crc_ok_out(crc_ok), .rx_store_in(rx_store_out),
        .rx_store_byte_in(rx_store_byte_out),
        .fifo_flush_in(fifo_flush_out), .body_ready_in(body_ready_flag_out));
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // ====================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input reg_byte_t d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input reg_byte_t e);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        `CHK(reg_rdata_out, e)
    endtask
    // Derived outputs trail a write by two edges
    task automatic settle;
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic final_report;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ====================
    // Scenarios
    task automatic t_reset;
        reg_byte_t rv [6] = '{8'h90, 8'h40, 8'h40, 8'h00, 8'h00, 8'h8F};
        for (int i = 0; i < 6; i++) rd_chk(8'h30 + 8'(i), rv[i]);
        rd_chk(8'h20, 8'h00);
        `CHK(body_len_out, 11'h040)
        `CHK({frame_length_kind_out, check_enable_out}, 2'b11)
        `CHK({processing_style_out, legacy_home_compat_out}, 2'b10)
    endtask
    task automatic t_fields;
        for (int c = 0; c < 4; c++) begin
            wr(8'h30, {1'b0, 2'(c), 5'h11});
            settle;
            `CHK(2'(line_balance_coding_out), (c == 3) ? 2'h0 : 2'(c))
        end
        `CHK({tx_len_from_reg_out, check_scramble_variant_out}, 2'b11)
        wr(8'h31, 8'hFD);
        settle;
        rd_chk(8'h31, 8'h7D);
        `CHK({processing_style_out, legacy_home_compat_out}, 2'b11)
        `CHK(beacon_active_out, 1'b1)
        `CHK(body_len_out, 11'h540)
        wr(8'h30, 8'h80);
        wr(8'h31, 8'h08);
        settle;
        `CHK({beacon_active_out, check_enable_out}, 2'b00)
        `CHK({processing_style_out, check_scramble_variant_out}, 2'b00)
        `CHK(tx_len_from_reg_out, 1'b0)
        wr(8'h31, 8'h40);
        wr(8'h30, 8'h90);
    endtask
    task automatic t_filter;
        logic [7:0] ad [3] = '{8'h5A, 8'hFF, 8'h33};
        int st, fl, rd;
        logic ok;
        wr(8'h33, 8'h5A);
        wr(8'h34, 8'hFF);
        // Reserved filter code 11 passes every frame, like 00
        for (int m = 0; m < 4; m++) begin
            wr(8'h30, 8'h90 | 8'(m << 1));
            settle;
            for (int k = 0; k < 3; k++) begin
                ok = (m == 0) || (m == 3) || (k == 0) || (m == 2 && k == 1);
                u_src.frame(ad[k], 2, m, 1'b1, st, fl, rd);
                `CHK({st == 3, rd == 1, fl == 0}, {3{ok}})
            end
        end
        `CHK(u_src.last_byte, 8'hA2)
        wr(8'h30, 8'h90);
    endtask
    task automatic t_bad;
        int st, fl, rd;
        wr(8'h3A, 8'h0F);
        wr(8'h39, 8'h04);
        u_src.frame(8'h11, 1, 0, 1'b0, st, fl, rd);
        `CHK({fl == 1, rd == 0, irq_out}, 3'b111)
        rd_chk(8'h38, 8'h04);
        wr(8'h3A, 8'h04);
        wr(8'h30, 8'h98);
        settle;
        `CHK(irq_out, 1'b0)
        u_src.frame(8'h12, 1, 1, 1'b0, st, fl, rd);
        `CHK({fl == 0, rd == 1}, 2'b11)
        wr(8'h39, 8'h00);
        settle;
        `CHK(irq_out, 1'b0)
        rd_chk(8'h38, 8'h05);
        wr(8'h30, 8'h80);
        wr(8'h32, 8'h02);
        settle;
        u_src.frame(8'h13, 0, 0, 1'b0, st, fl, rd);
        `CHK({fl == 0, rd == 1}, 2'b11)
        u_src.frame(8'h14, 4, 0, 1'b1, st, fl, rd);
        `CHK({fl != 0, rd == 0}, 2'b11)
        wr(8'h32, 8'h40);
        wr(8'h30, 8'h90);
    endtask
    task automatic t_level;
        logic [6:0] cn [5] = '{7'd0, 7'd1, 7'd5, 7'd6, 7'd7};
        for (int t = 0; t < 2; t++) begin
            wr(8'h35, (t == 1) ? 8'hC5 : 8'h45);
            for (int i = 0; i < 5; i++) begin
                @(posedge sys_clk_in);
                queue_count_in <= cn[i];
                settle;
                `CHK(queue_level_flag_out, cn[i] >= 7'd6)
                `CHK(tx_start_out, (t == 1) ? cn[i] != 0 : cn[i] > 5)
                `CHK(queue_empty_flag_out, cn[i] == 7'd0)
            end
        end
        rd_chk(8'h35, 8'h85);
        rd_chk(8'h38, 8'h0F);
        @(posedge sys_clk_in);
        queue_count_in <= 7'd0;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        final_report();
    end
    initial begin
        rstn_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        queue_count_in = 7'd0;
        repeat (8) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_fields();
        t_filter();
        t_bad();
        t_level();
        final_report();
    end
endmodule

// File: tb/pkt_handler_cfg_sva.sv
// Checker for the packet handler configuration block.
// Sees only the block's ports; bound in at the foot of this file.
`timescale 1ns/10ps
module pkt_handler_cfg_chk (
    // Clock and reset
    input wire logic                          sys_clk_in,
    input wire logic                          rstn_in,
    // Register port
    input wire logic [7:0]                    reg_addr_in,
    input wire pkt_handler_pkg::reg_byte_t    reg_wdata_in,
    input wire logic                          reg_wr_in,
    // Stream and queue
    input wire logic                          rx_byte_valid_in,
    input wire logic [7:0]                    rx_byte_in,
    input wire logic                          rx_crc_done_in,
    input wire logic [6:0]                    queue_count_in,
    // Block outputs
    input wire logic                          frame_length_kind_out,
    input wire pkt_handler_pkg::line_coding_t line_balance_coding_out,
    input wire logic                          beacon_active_out,
    input wire pkt_handler_pkg::body_len_t    body_len_out,
    input wire logic                          tx_len_from_reg_out,
    input wire logic                          rx_store_out,
    input wire logic [7:0]                    rx_store_byte_out,
    input wire logic                          fifo_flush_out,
    input wire logic                          rx_restart_out,
    input wire logic                          body_ready_flag_out,
    input wire logic                          queue_empty_flag_out
);
    import pkt_handler_pkg::*;
    // Reserved coding is expected to come out as none
    logic [1:0] cod_w;
    assign cod_w = (reg_wdata_in[6:5] == 2'h3) ? 2'h0 : reg_wdata_in[6:5];
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // ====================
    // Assertions
    pri_write_a: assert property (
        $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 8'h30 |->
        frame_length_kind_out == $past(reg_wdata_in[7], 2) &&
        2'(line_balance_coding_out) == $past(cod_w, 2))
        else $error("primary config write not reflected");
    len_low_a: assert property (
        $past(reg_wr_in, 2) && $past(reg_addr_in, 2) == 8'h32 |->
        body_len_out[7:0] == $past(reg_wdata_in, 2))
        else $error("length low byte not reflected");
    beacon_fixed_a: assert property (
        beacon_active_out |-> !frame_length_kind_out)
        else $error("beacon active with variable frames");
    tx_len_a: assert property (
        tx_len_from_reg_out == !frame_length_kind_out)
        else $error("send length source wrong");
    store_echo_a: assert property (
        rx_store_out |-> $past(rx_byte_valid_in) &&
        rx_store_byte_out == $past(rx_byte_in))
        else $error("stored byte without matching input byte");
    ready_cause_a: assert property (
        body_ready_flag_out |-> $past(rx_crc_done_in))
        else $error("body ready without frame end");
    ready_flush_a: assert property (
        body_ready_flag_out |-> !fifo_flush_out)
        else $error("body ready together with flush");
    restart_flush_a: assert property (
        rx_restart_out == fifo_flush_out)
        else $error("restart and flush disagree");
    empty_flag_a: assert property (
        $past(rstn_in) |->
        queue_empty_flag_out == ($past(queue_count_in) == 7'h00))
        else $error("empty flag does not follow count");
endmodule
bind pkt_handler_cfg pkt_handler_cfg_chk u_chk (
    .sys_clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .rx_byte_valid_in, .rx_byte_in, .rx_crc_done_in, .queue_count_in,
    .frame_length_kind_out, .line_balance_coding_out, .beacon_active_out,
    .body_len_out, .tx_len_from_reg_out, .rx_store_out, .rx_store_byte_out,
    .fifo_flush_out, .rx_restart_out, .body_ready_flag_out,
    .queue_empty_flag_out
);

// File: tb/rx_stream_model.sv
// Receive byte stream source in front of the packet handler.
// Assumes the bench calls frame() from one process at a time.
`timescale 1ns/10ps
module rx_stream_model (
    // Clock
    input  wire logic       sys_clk_in,
    // Stream towards the block
    output logic            rx_sync_out,
    output logic            rx_byte_valid_out,
    output logic [7:0]      rx_byte_out,
    output logic            rx_crc_done_out,
    output logic            rx_crc_ok_out,
    // Results from the block
    input  wire logic       rx_store_in,
    input  wire logic [7:0] rx_store_byte_in,
    input  wire logic       fifo_flush_in,
    input  wire logic       body_ready_in
);
    int         n_store = 0;
    int         n_flush = 0;
    int         n_ready = 0;
    logic [7:0] last_byte = 8'h00;
    initial begin
        rx_sync_out = 1'b0;
        rx_byte_valid_out = 1'b0;
        rx_byte_out = 8'h00;
        rx_crc_done_out = 1'b0;
        rx_crc_ok_out = 1'b0;
    end
    // ====================
    // Event counters
    always @(posedge sys_clk_in) begin
        if (rx_store_in) n_store <= n_store + 1;
        if (rx_store_in) last_byte <= rx_store_byte_in;
        if (fifo_flush_in) n_flush <= n_flush + 1;
        if (body_ready_in) n_ready <= n_ready + 1;
    end
    // ====================
    // Frame source
    // Idle data flips so a stale byte never passes for a fresh one
    task automatic idle;
        @(posedge sys_clk_in);
        rx_byte_valid_out <= 1'b0;
        rx_byte_out <= ~rx_byte_out;
    endtask
    task automatic frame(input logic [7:0] a, input int n, input int gap,
                         input logic ok, output int st, output int fl,
                         output int rd);
        int s0, f0, r0;
        s0 = n_store;
        f0 = n_flush;
        r0 = n_ready;
        @(posedge sys_clk_in);
        rx_sync_out <= 1'b1;
        idle();
        rx_sync_out <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (gap) idle();
            @(posedge sys_clk_in);
            rx_byte_valid_out <= 1'b1;
            rx_byte_out <= (i == 0) ? a : 8'hA0 + 8'(i);
        end
        idle();
        rx_crc_done_out <= 1'b1;
        rx_crc_ok_out <= ok;
        @(posedge sys_clk_in);
        rx_crc_done_out <= 1'b0;
        rx_crc_ok_out <= ~ok;
        repeat (4) @(posedge sys_clk_in);
        st = n_store - s0;
        fl = n_flush - f0;
        rd = n_ready - r0;
    endtask
endmodule
